// ---- src/rwa_word_aligner.v ----
// rwa_word_aligner.v: receive word aligner with manual, bit-slip and automatic
// sync modes, run length check, polarity inversion and bit reversal.
// assumes des_data_i comes from the deserializer on clk_i (the parallel recovered
// clock), lsb received first; fabric controls may come from another clock.
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ns
`include "rwa_map.vh"

// Contract
// - manual, bit-slip and automatic modes; pattern lengths 16 or 7/10 bits by width.
// - 8-bit manual: align-enable rising edge after reset starts a pattern search.
// - 8-bit manual: realign to a new boundary only after a fresh rising edge.
// - 10-bit manual: while enable high, search pattern or complement, update boundary.
// - 10-bit manual: enable low keeps the present boundary.
// - manual: boundary update pulses sync and detect one cycle with pattern MSB word.
// - sync and detect carry the same latency as the data path.
// - manual: pattern at established boundary pulses detect only.
// - bit-slip: each slip request rising edge shifts the boundary by one bit.
// - bit-slip: slipped data matching pattern pulses detect for one cycle.
// - automatic mode only with 8b/10b data at 10-bit width.
// - loss count 1 to 64 and good-run count 1 to 256 are programmable.
// - automatic: after reset search sync groups; sync high after programmed count.
// - automatic: sync drops after programmed errors without good groups; reacquire.
// - run length flag at thresholds 4..128 step 4 or 5..160 step 5.
// - run length output lasts at least two clock cycles.
// - polarity invert flips every input bit, changeable at any time.
// - polarity invert is unavailable in pipe mode.
// - bit reversal reverses output order; static, dynamic only in bit-slip.
// - number of bits slipped is reported on its own output.
// - input words are 8 or 10 bits, lsb first.
module rwa_word_aligner (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // deserializer data
    input wire [9:0] des_data_i,
    // fabric controls
    input wire align_en_i,
    input wire slip_req_i,
    input wire inv_pol_i,
    input wire rev_order_i,
    // aligned stream and status
    output reg [9:0] data_o,
    output reg sync_status_o,
    output reg pat_det_o,
    output wire rlv_o,
    output wire [3:0] slip_count_o
);

    localparam [1:0] ST_LOSS = 2'b00;
    localparam [1:0] ST_SYNC = 2'b01;

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // twenty-bit window starting k bits into the history
    function [19:0] win_at;
        input [29:0] h;
        input [3:0] k;
        reg [29:0] t;
        begin
            t = h >> k;
            win_at = t[19:0];
        end
    endfunction

    // pattern compare on a window; complement accepted at 10-bit width
    function is_match;
        input [19:0] c;
        input w10;
        input len7;
        input [15:0] pat;
        reg [9:0] m;
        begin
            m = len7 ? `RWA_MASK7 : `RWA_MASK10;
            if (w10) begin
                is_match = ((c[19:10] & m) == (pat[9:0] & m)) || ((c[19:10] & m) == (~pat[9:0] & m));
            end else begin
                is_match = (c[15:0] == pat);
            end
        end
    endfunction

    // newest word of a window
    function [9:0] out_word;
        input [19:0] c;
        input w10;
        begin
            out_word = w10 ? c[19:10] : {2'b00, c[15:8]};
        end
    endfunction

    // bit order reversal within the active width
    function [9:0] rev_word;
        input [9:0] w;
        input w10;
        integer i;
        begin
            rev_word = 10'h000;
            for (i = 0; i < 10; i = i + 1) begin
                if (w10) begin
                    rev_word[i] = w[9 - i];
                end else if (i < 8) begin
                    rev_word[i] = w[7 - i];
                end
            end
        end
    endfunction

    // count of ones in a 10-bit code group
    function [3:0] ones;
        input [9:0] w;
        integer i;
        begin
            ones = 4'h0;
            for (i = 0; i < 10; i = i + 1) begin
                ones = ones + {3'b000, w[i]};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers

    reg [31:0] ctrl_q;
    reg [31:0] pat_q;
    reg [31:0] smcfg_q;
    reg [31:0] rlvcfg_q;
    reg rlv_sticky_q;

    wire [1:0] mode = ctrl_q[`RWA_CTRL_MODE_HI:`RWA_CTRL_MODE_LO];
    wire w10 = ctrl_q[`RWA_CTRL_W10];
    wire len7 = ctrl_q[`RWA_CTRL_LEN7];
    wire pipe_mode = ctrl_q[`RWA_CTRL_PIPE];
    wire enc = ctrl_q[`RWA_CTRL_ENC];
    wire [3:0] last_bit = w10 ? `RWA_W10_LAST : `RWA_W8_LAST;
    wire auto_ok = (mode == `RWA_MODE_AUTO) && w10 && enc;

    ////////////////////////////////////////////////////////////////////////////
    // control input synchronisers: three flops, change taken when 2nd and 3rd agree

    reg [3:0] s1_q;
    reg [3:0] s2_q;
    reg [3:0] s3_q;
    reg [3:0] flt_q;
    reg [3:0] flt_prev_q;
    wire [3:0] rise = flt_q & ~flt_prev_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            s3_q <= 4'h0;
            flt_q <= 4'h0;
            flt_prev_q <= 4'h0;
        end else begin
            s1_q <= {rev_order_i, inv_pol_i, slip_req_i, align_en_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q));
            flt_prev_q <= flt_q;
        end
    end

    wire en_lvl = flt_q[0];
    wire en_rise = rise[0];
    wire slip_rise = rise[1];
    wire inv_on = flt_q[2] & ~pipe_mode;
    wire rev_on = (mode == `RWA_MODE_SLIP) ? flt_q[3] : ctrl_q[`RWA_CTRL_REV];

    ////////////////////////////////////////////////////////////////////////////
    // input inversion and word history

    wire [9:0] cur = inv_on ? ~des_data_i : des_data_i;
    reg [9:0] p1_q;
    reg [9:0] p2_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            p1_q <= 10'h000;
            p2_q <= 10'h000;
        end else begin
            p1_q <= cur;
            p2_q <= p1_q;
        end
    end

    // lsb-first history, newest word highest
    wire [29:0] hist = w10 ? {cur, p1_q, p2_q} : {6'h00, cur[7:0], p1_q[7:0], p2_q[7:0]};

    ////////////////////////////////////////////////////////////////////////////
    // pattern search over all boundaries

    reg [3:0] bnd_q;
    reg found;
    reg [3:0] found_k;
    integer k;

    always @* begin
        found = 1'b0;
        found_k = 4'h0;
        for (k = 0; k < 10; k = k + 1) begin
            if (k[3:0] <= last_bit && !found &&
                is_match(win_at(hist, k[3:0]), w10, len7, pat_q[15:0])) begin
                found = 1'b1;
                found_k = k[3:0];
            end
        end
    end

    wire match_b = is_match(win_at(hist, bnd_q), w10, len7, pat_q[15:0]);

    ////////////////////////////////////////////////////////////////////////////
    // alignment control for all three modes

    reg armed_q;
    reg [1:0] st_q;
    reg [4:0] gsync_q;
    reg [6:0] err_q;
    reg [8:0] grun_q;
    reg [3:0] bnd_d;
    reg armed_d;
    reg [1:0] st_d;
    reg [4:0] gsync_d;
    reg [6:0] err_d;
    reg [8:0] grun_d;
    reg sync_d;
    reg det_d;
    reg [3:0] bsel;
    reg [4:0] gnext;

    wire [4:0] sync_need = {1'b0, smcfg_q[`RWA_SM_SYNC_HI:`RWA_SM_SYNC_LO]} + 5'h01;
    wire [6:0] err_need = {1'b0, smcfg_q[`RWA_SM_ERR_HI:`RWA_SM_ERR_LO]} + 7'h01;
    wire [8:0] good_need = {1'b0, smcfg_q[`RWA_SM_GOOD_HI:`RWA_SM_GOOD_LO]} + 9'h001;
    wire [9:0] word_b = out_word(win_at(hist, bnd_q), w10);
    wire [3:0] word_ones = ones(word_b);
    wire word_bad = (word_ones < `RWA_ONES_MIN) || (word_ones > `RWA_ONES_MAX);

    always @* begin
        bnd_d = bnd_q;
        armed_d = armed_q;
        st_d = st_q;
        gsync_d = gsync_q;
        err_d = err_q;
        grun_d = grun_q;
        sync_d = 1'b0;
        det_d = 1'b0;
        gnext = 5'h00;
        case (mode)
            `RWA_MODE_MANUAL: begin
                if (!w10) begin
                    if (en_rise) begin
                        armed_d = 1'b1;
                    end
                    if (match_b) begin
                        det_d = 1'b1;
                        armed_d = 1'b0;
                    end else if (armed_q && found) begin
                        bnd_d = found_k;
                        armed_d = 1'b0;
                        sync_d = 1'b1;
                        det_d = 1'b1;
                    end
                end else begin
                    armed_d = 1'b0;
                    if (match_b) begin
                        det_d = 1'b1;
                    end else if (en_lvl && found) begin
                        bnd_d = found_k;
                        sync_d = 1'b1;
                        det_d = 1'b1;
                    end
                end
            end
            `RWA_MODE_SLIP: begin
                if (slip_rise) begin
                    bnd_d = (bnd_q >= last_bit) ? 4'h0 : bnd_q + 4'h1;
                end
                det_d = match_b;
            end
            `RWA_MODE_AUTO: begin
                if (!auto_ok) begin
                    st_d = ST_LOSS;
                    gsync_d = 5'h00;
                end else begin
                    case (st_q)
                        ST_LOSS: begin
                            if (match_b) begin
                                det_d = 1'b1;
                                gnext = gsync_q + 5'h01;
                            end else if (found) begin
                                bnd_d = found_k;
                                det_d = 1'b1;
                                gnext = 5'h01;
                            end else begin
                                gnext = gsync_q;
                            end
                            gsync_d = gnext;
                            if (gnext >= sync_need) begin
                                st_d = ST_SYNC;
                                gsync_d = 5'h00;
                                err_d = 7'h00;
                                grun_d = 9'h000;
                            end
                        end
                        ST_SYNC: begin
                            det_d = match_b;
                            if (word_bad) begin
                                grun_d = 9'h000;
                                err_d = err_q + 7'h01;
                                if (err_q + 7'h01 >= err_need) begin
                                    st_d = ST_LOSS;
                                    gsync_d = 5'h00;
                                end
                            end else if (err_q != 7'h00) begin
                                grun_d = grun_q + 9'h001;
                                if (grun_q + 9'h001 >= good_need) begin
                                    err_d = err_q - 7'h01;
                                    grun_d = 9'h000;
                                end
                            end
                        end
                        default: begin
                            st_d = ST_LOSS;
                        end
                    endcase
                end
                sync_d = (st_d == ST_SYNC);
            end
            default: begin
                armed_d = 1'b0;
            end
        endcase
        // a boundary found this cycle also selects this cycle's output word
        bsel = (mode == `RWA_MODE_SLIP) ? bnd_q : bnd_d;
    end

    wire [9:0] word_sel = out_word(win_at(hist, bsel), w10);

    // state, boundary and aligned outputs on one register stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            bnd_q <= 4'h0;
            armed_q <= 1'b0;
            st_q <= ST_LOSS;
            gsync_q <= 5'h00;
            err_q <= 7'h00;
            grun_q <= 9'h000;
            data_o <= 10'h000;
            sync_status_o <= 1'b0;
            pat_det_o <= 1'b0;
        end else begin
            bnd_q <= bnd_d;
            armed_q <= armed_d;
            st_q <= st_d;
            gsync_q <= gsync_d;
            err_q <= err_d;
            grun_q <= grun_d;
            data_o <= rev_on ? rev_word(word_sel, w10) : word_sel;
            sync_status_o <= sync_d;
            pat_det_o <= det_d;
        end
    end

    assign slip_count_o = bnd_q;

    ////////////////////////////////////////////////////////////////////////////
    // run length violation check on the input stream after optional polarity inversion

    reg [7:0] run_q;
    reg last_q;
    reg [1:0] hold_q;
    reg [7:0] run_d;
    reg last_d;
    reg viol;
    integer i;

    wire [7:0] steps = {3'b000, rlvcfg_q[`RWA_RLV_HI:`RWA_RLV_LO]} + 8'h01;
    wire [7:0] rlv_thr = steps * (w10 ? `RWA_RLV_UNIT10 : `RWA_RLV_UNIT8);

    always @* begin
        run_d = run_q;
        last_d = last_q;
        viol = 1'b0;
        for (i = 0; i < 10; i = i + 1) begin
            if (i[3:0] <= last_bit) begin
                if (cur[i] == last_d) begin
                    run_d = (run_d == 8'hFF) ? run_d : run_d + 8'h01;
                end else begin
                    run_d = 8'h01;
                end
                last_d = cur[i];
                if (run_d >= rlv_thr) begin
                    viol = 1'b1;
                end
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= 8'h00;
            last_q <= 1'b0;
            hold_q <= 2'h0;
        end else begin
            run_q <= run_d;
            last_q <= last_d;
            if (viol) begin
                hold_q <= `RWA_RLV_HOLD;
            end else if (hold_q != 2'h0) begin
                hold_q <= hold_q - 2'h1;
            end
        end
    end

    assign rlv_o = (hold_q != 2'h0);

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave: ack one cycle after the strobe, unmapped reads zero

    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i;
    wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wnew_ctrl = (ctrl_q & ~wmask) | (wb_dat_i & wmask);
    wire [31:0] wnew_pat = (pat_q & ~wmask) | (wb_dat_i & wmask);
    wire [31:0] wnew_sm = (smcfg_q & ~wmask) | (wb_dat_i & wmask);
    wire [31:0] wnew_rlv = (rlvcfg_q & ~wmask) | (wb_dat_i & wmask);
    wire st_clr = wb_wr && (wb_adr_i == `RWA_ADR_STATUS) && wmask[`RWA_ST_RLV] && wb_dat_i[`RWA_ST_RLV];

    reg [31:0] rd_d;

    // read data mux
    always @* begin
        rd_d = 32'h0000_0000;
        case (wb_adr_i)
            `RWA_ADR_CTRL: rd_d = ctrl_q;
            `RWA_ADR_PAT: rd_d = pat_q;
            `RWA_ADR_SMCFG: rd_d = smcfg_q;
            `RWA_ADR_RLVCFG: rd_d = rlvcfg_q;
            `RWA_ADR_STATUS: begin
                rd_d[`RWA_ST_SYNC] = sync_status_o;
                rd_d[`RWA_ST_RLV] = rlv_sticky_q;
                rd_d[`RWA_ST_AUTO] = (st_q == ST_SYNC);
                rd_d[`RWA_ST_BND_HI:`RWA_ST_BND_LO] = bnd_q;
            end
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // register writes, ack and read data
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `RWA_CTRL_RST;
            pat_q <= `RWA_PAT_RST;
            smcfg_q <= `RWA_SMCFG_RST;
            rlvcfg_q <= `RWA_RLVCFG_RST;
            rlv_sticky_q <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req) begin
                wb_dat_o <= rd_d;
            end
            if (wb_wr && wb_adr_i == `RWA_ADR_CTRL) begin
                ctrl_q <= wnew_ctrl;
            end
            if (wb_wr && wb_adr_i == `RWA_ADR_PAT) begin
                pat_q <= wnew_pat;
            end
            if (wb_wr && wb_adr_i == `RWA_ADR_SMCFG) begin
                smcfg_q <= wnew_sm;
            end
            if (wb_wr && wb_adr_i == `RWA_ADR_RLVCFG) begin
                rlvcfg_q <= wnew_rlv;
            end
            // a violation in the clearing cycle keeps the flag set
            if (viol) begin
                rlv_sticky_q <= 1'b1;
            end else if (st_clr) begin
                rlv_sticky_q <= 1'b0;
            end
        end
    end

endmodule

// ---- common/rwa_map.vh ----
// rwa_map.vh: register offsets, field positions, reset values and counts
// for the receive word aligner; definitions only, included by bare name.
`ifndef RWA_MAP_VH
`define RWA_MAP_VH

// register byte offsets on the wishbone slave
`define RWA_ADR_CTRL 8'h00
`define RWA_ADR_PAT 8'h04
`define RWA_ADR_SMCFG 8'h08
`define RWA_ADR_RLVCFG 8'h0C
`define RWA_ADR_STATUS 8'h10

// control register fields
`define RWA_CTRL_MODE_LO 0
`define RWA_CTRL_MODE_HI 1
`define RWA_CTRL_W10 2
`define RWA_CTRL_LEN7 3
`define RWA_CTRL_REV 4
`define RWA_CTRL_PIPE 5
`define RWA_CTRL_ENC 6
`define RWA_CTRL_RST 32'h0000_0044

// operating modes
`define RWA_MODE_MANUAL 2'h0
`define RWA_MODE_SLIP 2'h1
`define RWA_MODE_AUTO 2'h2

// pattern register and masks
`define RWA_PAT_RST 32'h0000_017C
`define RWA_MASK7 10'h07F
`define RWA_MASK10 10'h3FF

// sync machine configuration: each field holds count minus one
`define RWA_SM_ERR_LO 0
`define RWA_SM_ERR_HI 5
`define RWA_SM_GOOD_LO 8
`define RWA_SM_GOOD_HI 15
`define RWA_SM_SYNC_LO 16
`define RWA_SM_SYNC_HI 19
`define RWA_SMCFG_RST 32'h0002_0303

// run length configuration: steps minus one
`define RWA_RLV_LO 0
`define RWA_RLV_HI 4
`define RWA_RLVCFG_RST 32'h0000_001F
`define RWA_RLV_UNIT8 8'h04
`define RWA_RLV_UNIT10 8'h05
`define RWA_RLV_HOLD 2'h2

// status register fields
`define RWA_ST_SYNC 0
`define RWA_ST_RLV 1
`define RWA_ST_AUTO 2
`define RWA_ST_BND_LO 4
`define RWA_ST_BND_HI 7

// word widths and 8b/10b disparity limits
`define RWA_W8_LAST 4'h7
`define RWA_W10_LAST 4'h9
`define RWA_ONES_MIN 4'h4
`define RWA_ONES_MAX 4'h6

`endif

// ---- bench/rwa_word_aligner_chk.sv ----
// rwa_word_aligner_chk.sv: port assertions for the word aligner.
// assumes one clock and the synchronous active-high reset of the top.
`timescale 1ns/1ns
module rwa_word_aligner_chk (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    // stream outputs
    input wire [9:0] data_o,
    input wire sync_status_o,
    input wire pat_det_o,
    input wire rlv_o,
    input wire [3:0] slip_count_o
);
    logic [7:0] ctrl_q;
    wire manual = ctrl_q[1:0] == 2'h0;
    wire slip_m = ctrl_q[1:0] == 2'h1;
    wire auto_bad = ctrl_q[1:0] == 2'h2 && !(ctrl_q[2] && ctrl_q[6]);
    wire [3:0] last = ctrl_q[2] ? 4'h9 : 4'h7;
    // shadow of the control byte, taken with the write request
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= 8'h44;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]) begin
            ctrl_q <= wb_dat_i[7:0];
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ack_resp_a: assert property (s_take |=> s_ack) else $error("bus ack missing or long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    rst_out_a: assert property ($fell(rst_i) |-> data_o == 10'h000 && !sync_status_o && !pat_det_o
        && !wb_ack_o && !rlv_o && slip_count_o == 4'h0) else $error("outputs not cleared by reset");
    sync_pair_a: assert property (manual && sync_status_o |-> pat_det_o)
        else $error("sync pulse without detect");
    sync_one_a: assert property (manual && sync_status_o |=> !sync_status_o)
        else $error("manual sync longer than one cycle");
    slip_step_a: assert property (slip_m && $past(slip_m) && !$stable(slip_count_o) |->
        slip_count_o == ($past(slip_count_o) == last ? 4'h0 : $past(slip_count_o) + 4'h1))
        else $error("slip count moved by other than one");
    auto_off_a: assert property (auto_bad [*3] |-> !sync_status_o)
        else $error("auto sync in unsupported setup");
    rlv_hold_a: assert property ($rose(rlv_o) |=> rlv_o) else $error("run flag shorter than two");
endmodule
bind rwa_word_aligner rwa_word_aligner_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .data_o, .sync_status_o, .pat_det_o, .rlv_o, .slip_count_o);

// ---- bench/rwa_des_model.sv ----
// rwa_des_model.sv: deserializer in front of the aligner.
// repeats one word serially, lsb first, and cuts it skew bits late.
`timescale 1ns/1ns
module rwa_des_model (
    // clock and stream setup
    input wire clk_i,
    input wire w10_i,
    input wire [9:0] word_i,
    input wire [3:0] skew_i,
    // parallel words
    output logic [9:0] des_o = 10'h000
);
    // word rotated by the skew, 8 or 10 bits, unused top bits low
    always @(posedge clk_i) begin
        des_o <= w10_i ? 10'({word_i, word_i} >> skew_i) : {2'h0, 8'({word_i[7:0], word_i[7:0]} >> skew_i)};
    end
endmodule

// ---- bench/rwa_word_aligner_test.sv ----
// rwa_word_aligner_test.sv: self-checking bench for the word aligner.
// assumes the deserializer model and the bound checker compile first.
`timescale 1ns/1ns
module rwa_word_aligner_test;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic aen = 0, slp = 0, inv = 0, rev = 0, mw10 = 1;
    logic [7:0] adr = 8'h00;
    logic [3:0] skew = 4'h0;
    logic [9:0] word = 10'h155, e;
    logic [31:0] wdat = 32'h0, rd;
    logic [7:0] ra [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
    logic [31:0] rv [4] = '{32'h0000_0044, 32'h0000_017C, 32'h0002_0303, 32'h0000_001F};
    logic [31:0] ab [2] = '{32'h0000_0042, 32'h0000_0006};
    wire [31:0] wb_dat_o;
    wire [9:0] des, data_o;
    wire [3:0] slip_count_o;
    wire wb_ack_o, sync_status_o, pat_det_o, rlv_o;
    int n_errors = 0, check_count = 0, b, k, i, ns;
    localparam logic [9:0] pat_v = 10'h17C;
    always #5 clk_i = ~clk_i;
    rwa_des_model u_des (.clk_i(clk_i), .w10_i(mw10), .word_i(word), .skew_i(skew), .des_o(des));
    rwa_word_aligner u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .des_data_i(des), .align_en_i(aen), .slip_req_i(slp), .inv_pol_i(inv), .rev_order_i(rev),
        .data_o(data_o), .sync_status_o(sync_status_o), .pat_det_o(pat_det_o), .rlv_o(rlv_o),
        .slip_count_o(slip_count_o));
    ////////////////////////////////////////
    function automatic logic [9:0] rotr(input logic [9:0] v, input int s);
        logic [19:0] d;
        d = {v, v} >> (s % 10);
        return d[9:0];
    endfunction
    function automatic logic [9:0] rev10(input logic [9:0] v);
        for (int j = 0; j < 10; j++) rev10[j] = v[9 - j];
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task tick(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    // one classic cycle, held until ack is sampled
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        if (n >= 20) n_errors++;
        cyc <= 0;
        stb <= 0;
    endtask
    task slip1;
        slp <= 1;
        tick(6);
        slp <= 0;
        tick(6);
        b = (b + 1) % 10;
    endtask
    task wsync(input logic v);
        for (int j = 0; j < 60 && sync_status_o !== v; j++) @(posedge clk_i);
        chk(sync_status_o, v);
    endtask
    task nsync(input int c);
        ns = 0;
        repeat (c) begin
            @(posedge clk_i);
            if (sync_status_o === 1'b1) begin
                ns++;
                chk(data_o, e);
            end
        end
    endtask
    // cut a hang short
    initial begin
        #200000;
        n_errors++;
        conclude;
    end
    ////////////////////////////////////////
    initial begin
        void'($urandom(89945));
        tick(3);
        rst_i <= 0;
        // reset values, unmapped write and read
        wb(8'h14, 1, 32'hFFFF_FFFF);
        wb(8'h14, 0, 32'h0);
        chk(rd, 32'h0);
        foreach (ra[j]) begin
            wb(ra[j], 0, 32'h0);
            chk(rd, rv[j]);
        end
        $display("test regs done");
        // bit slip with random word, then polarity and reversal
        wb(8'h00, 1, 32'h0000_0045);
        word <= 10'($urandom);
        b = 0;
        repeat ($urandom_range(12, 1)) begin
            slip1;
            chk(slip_count_o, b);
            chk(data_o, rotr(word, b));
        end
        for (i = 0; i < 4; i++) begin
            inv <= i[0];
            rev <= i[1];
            tick(10);
            e = rotr(i[0] ? ~word : word, b);
            chk(data_o, i[1] ? rev10(e) : e);
        end
        wb(8'h00, 1, 32'h0000_0065);
        rev <= 0;
        tick(10);
        chk(data_o, rotr(word, b));
        inv <= 0;
        word <= pat_v;
        skew <= 4'($urandom_range(9, 0));
        tick(10);
        for (i = 0; i < 10 && pat_det_o !== 1'b1; i++) slip1;
        chk((b + skew) % 10, 0);
        chk(data_o, pat_v);
        $display("test slip done");
        // manual 10-bit: search while enabled, then lock
        wb(8'h00, 1, 32'h0000_0044);
        k = (int'(skew) + $urandom_range(9, 1)) % 10;
        skew <= 4'(k);
        aen <= 1;
        e = pat_v;
        nsync(30);
        chk(ns, 1);
        aen <= 0;
        tick(8);
        i = $urandom_range(9, 1);
        skew <= 4'((k + i) % 10);
        tick(10);
        chk(data_o, rotr(pat_v, i));
        chk(pat_det_o, 1'b0);
        skew <= 4'(k);
        nsync(20);
        chk(ns, 0);
        chk(pat_det_o, 1'b1);
        $display("test manual done");
        // automatic: acquire, ride out three errors, lose on four
        wb(8'h00, 1, 32'h0000_0046);
        skew <= 4'h0;
        word <= pat_v;
        wsync(1'b1);
        word <= 10'h000;
        tick(3);
        word <= pat_v;
        tick(20);
        chk(sync_status_o, 1'b1);
        word <= 10'h000;
        wsync(1'b0);
        word <= pat_v;
        wsync(1'b1);
        foreach (ab[j]) begin
            wb(8'h00, 1, ab[j]);
            tick(10);
            chk(sync_status_o, 1'b0);
        end
        $display("test auto done");
        // run length at one and two steps, both widths
        for (i = 0; i < 2; i++) begin
            mw10 <= (i == 0);
            word <= i ? 10'h0F0 : 10'h3E0;
            wb(8'h00, 1, i ? 32'h0000_0040 : 32'h0000_0044);
            wb(8'h0C, 1, 32'h0000_0001);
            tick(20);
            chk(rlv_o, 1'b0);
            wb(8'h0C, 1, 32'h0000_0000);
            tick(10);
            chk(rlv_o, 1'b1);
        end
        $display("test runlength done");
        // manual 8-bit, reversed output: realign only on fresh edges
        wb(8'h04, 1, 32'h0000_F0F0);
        wb(8'h00, 1, 32'h0000_0050);
        e = 10'h00F;
        for (i = 0; i < 3; i++) begin
            if (i < 2) k = (i * k + $urandom_range(7, 1)) % 8;
            skew <= 4'(k);
            tick(4);
            aen <= (i != 1);
            nsync(16);
            if (i != 1) b = (8 - k) % 8;
            chk(ns, i != 1);
            chk(slip_count_o, b);
            aen <= 0;
        end
        $display("test manual8 done");
        conclude;
    end
endmodule
